//--- src/power_down_pkg.sv
// Purpose: Shared constants and types for the power-down mode controller
// Assumes: 8-bit register port, 16 peripheral modules split over two halt registers
// Notes:   Offsets are byte indices on the plain register port

package power_down_pkg;

  // ==========================================================================
  // Sizes
  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned DATA_W    = 8;
  localparam int unsigned MOD_COUNT = 16;
  localparam int unsigned IRQ_COUNT = 3;
  localparam int unsigned SYNC_W    = IRQ_COUNT + 3;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] SYS_CTRL_OFFSET  = 8'h00;
  localparam logic [7:0] HALT_HIGH_OFFSET = 8'h01;
  localparam logic [7:0] HALT_LOW_OFFSET  = 8'h02;
  localparam logic [7:0] STATUS_OFFSET    = 8'h03;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] SYS_CTRL_RESET  = 8'h09;
  localparam logic [7:0] HALT_HIGH_RESET = 8'h78;
  localparam logic [7:0] HALT_LOW_RESET  = 8'h00;

  // Pin synchroniser idle levels: {standby_n, reset_n, nmi, irq[2:0]}
  localparam logic [SYNC_W-1:0] SYNC_RESET = 6'h30;

  // ==========================================================================
  // Field positions
  localparam int unsigned SLEEP_SELECT_BIT = 7;
  localparam int unsigned RAM_ENABLE_BIT   = 0;
  localparam int unsigned SYNC_STANDBY_BIT  = 5;
  localparam int unsigned SYNC_RESETPIN_BIT = 4;
  localparam int unsigned SYNC_NMI_BIT     = 3;

  // Module index of the DRAM interface within {halt_high, halt_low}
  localparam int unsigned DRAM_MODULE_BIT = 10;
  localparam logic [MOD_COUNT-1:0] DRAM_MASK = 16'h0001 << DRAM_MODULE_BIT;

  // ==========================================================================
  // Power states
  typedef enum logic [1:0] {
    ST_RUN,
    ST_SW_STANDBY,
    ST_HW_STANDBY
  } power_state_type;

endpackage

//--- src/module_standby_gate.sv
// Purpose: Halt and reset control for one peripheral module
// Assumes: Standby inputs are next-state flags from the controller, same clock
// Notes:   HOLD_IN_SOFT keeps module registers (DRAM) instead of resetting them, except in hardware standby

`timescale 1ns/100ps

module module_standby_gate #(
  parameter bit HOLD_IN_SOFT = 1'b0
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic reset,
  // Control
  input  wire logic halt_bit,
  input  wire logic sw_standby_next,
  input  wire logic hw_standby_next,
  // Module side
  output logic      module_halt,
  output logic      module_reset
);

  // ==========================================================================
  // Halt follows any standby cause; reset is skipped for a held module except in hardware standby
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      module_halt <= 1'b0;
    end else begin
      module_halt <= halt_bit | sw_standby_next | hw_standby_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      module_reset <= 1'b0;
    end else if (HOLD_IN_SOFT) begin
      // Module standby and software standby both keep its registers
      module_reset <= hw_standby_next;
    end else begin
      module_reset <= halt_bit | sw_standby_next | hw_standby_next;
    end
  end

endmodule // module_standby_gate

//--- src/power_down_ctrl.sv
// Purpose: Power-down mode controller: software, hardware and module standby
// Assumes: Core and register port on clk_sys; standby, reset, NMI and IRQ are pins
// Notes:   clock_stop tells the clock generator to stop; this logic keeps running
//
// Summary of operation
// RULE1: Sleep instruction with select bit 1 enters software standby, halting clock and core.
// RULE2: Software standby ends on NMI, IRQ0..2, reset pin or standby pin.
// RULE3: Both standby modes initialise refresh counter and refresh status bits 7..6.
// RULE4: Standby pin low enters hardware standby: all modules reset, ports float.
// RULE5: Software clears RAM enable before hardware standby is entered.
// RULE6: A set halt bit halts its module while clock and core keep running.
// RULE7: Setting a halt bit returns that module's registers to initial values. The DRAM module (bit 10) is halted but not reset.
// RULE8: Module standby ends on halt bit clear, reset pin or standby pin.
// RULE9: Software clears a halt bit before reprogramming that module.
// RULE10: Software standby resets all modules but DRAM, holds RAM and ports, clock pin high.
// RULE11: Select bit picks software standby or sleep; it survives an interrupt exit.
//
// The strobed register port and the register addresses were left to the implementer.

`timescale 1ns/100ps

module power_down_ctrl (
  // Clock and reset
  input  wire logic                                     clk_sys,
  input  wire logic                                     reset,
  // Register port
  input  wire logic [power_down_pkg::ADDR_W-1:0]        reg_addr,
  input  wire logic [power_down_pkg::DATA_W-1:0]        reg_wdata,
  input  wire logic                                     reg_write,
  input  wire logic                                     reg_read,
  output logic      [power_down_pkg::DATA_W-1:0]        reg_rdata,
  // Processor core
  input  wire logic                                     sleep_exec,
  output logic                                          core_halt,
  output logic                                          clock_stop,
  output logic                                          core_regs_undefined,
  output logic                                          sleep_mode_req,
  // Pins
  input  wire logic                                     standby_pin_n,
  input  wire logic                                     reset_pin_n,
  input  wire logic                                     nmi_pin,
  input  wire logic [power_down_pkg::IRQ_COUNT-1:0]     irq_pin,
  output logic                                          clock_out_high,
  output logic                                          io_hiz,
  // Peripheral modules
  output logic      [power_down_pkg::MOD_COUNT-1:0]     periph_halt,
  output logic      [power_down_pkg::MOD_COUNT-1:0]     periph_reset,
  output logic                                          refresh_init,
  output logic                                          onchip_ram_enable
);

  import power_down_pkg::*;

  power_state_type       state_reg;
  power_state_type       state_next;
  logic [SYNC_W-1:0]     sync1_reg;
  logic [SYNC_W-1:0]     sync2_reg;
  logic [DATA_W-1:0]     system_control_reg;
  logic [DATA_W-1:0]     module_halt_ctrl_high;
  logic [DATA_W-1:0]     module_halt_ctrl_low;
  logic [MOD_COUNT-1:0]  module_halt_ctrl;
  logic                  standby_ok;
  logic                  reset_pin_ok;
  logic                  nmi_seen;
  logic                  irq_seen;
  logic                  sleep_target_select;
  logic                  regs_to_initial;
  logic                  sw_next;
  logic                  hw_next;

  // ==========================================================================
  // Pin synchronisers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sync1_reg <= SYNC_RESET;
      sync2_reg <= SYNC_RESET;
    end else begin
      sync1_reg <= {standby_pin_n, reset_pin_n, nmi_pin, irq_pin};
      sync2_reg <= sync1_reg;
    end
  end

  assign standby_ok          = sync2_reg[SYNC_STANDBY_BIT];
  assign reset_pin_ok        = sync2_reg[SYNC_RESETPIN_BIT];
  assign nmi_seen            = sync2_reg[SYNC_NMI_BIT];
  assign irq_seen            = |sync2_reg[IRQ_COUNT-1:0];
  assign sleep_target_select = system_control_reg[SLEEP_SELECT_BIT];
  assign module_halt_ctrl    = {module_halt_ctrl_high, module_halt_ctrl_low};

  // ==========================================================================
  // Power state machine
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN: begin
        if (!standby_ok) begin
          state_next = ST_HW_STANDBY;                                     // [RULE4]
        end else if (sleep_exec && sleep_target_select && reset_pin_ok) begin
          state_next = ST_SW_STANDBY;                                     // [RULE1] [RULE11]
        end
      end
      ST_SW_STANDBY: begin
        if (!standby_ok) begin
          state_next = ST_HW_STANDBY;                                     // [RULE2] [RULE4]
        end else if (nmi_seen || irq_seen || !reset_pin_ok) begin
          state_next = ST_RUN;                                            // [RULE2]
        end
      end
      ST_HW_STANDBY: begin
        if (standby_ok) begin
          state_next = ST_RUN;
        end
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_reg <= ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sw_next = (state_next == ST_SW_STANDBY);
  assign hw_next = (state_next == ST_HW_STANDBY);

  // ==========================================================================
  // Core and pin controls, registered from the next state except the sleep request
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      core_halt  <= 1'b0;
      clock_stop <= 1'b0;
    end else begin
      // Module standby alone never stops the clock or the core
      core_halt  <= (state_next != ST_RUN);                               // [RULE1] [RULE6]
      clock_stop <= (state_next != ST_RUN);                               // [RULE1] [RULE6]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      core_regs_undefined <= 1'b0;
      io_hiz              <= 1'b0;
    end else begin
      core_regs_undefined <= hw_next;                                     // [RULE4]
      io_hiz              <= hw_next;                                     // [RULE4]
    end
  end

  // Port states are held in software standby; only the clock pin is forced
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      clock_out_high <= 1'b0;
    end else begin
      clock_out_high <= sw_next;                                          // [RULE10]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      refresh_init <= 1'b0;
    end else begin
      refresh_init <= (state_next != ST_RUN);                             // [RULE3]
    end
  end

  // Sleep mode itself lives in the core; only the request is raised here
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sleep_mode_req <= 1'b0;
    end else begin
      sleep_mode_req <= (state_reg == ST_RUN) && sleep_exec && !sleep_target_select
                        && standby_ok && reset_pin_ok;                    // [RULE11]
    end
  end

  // ==========================================================================
  // Control registers
  // Reset pin and hardware standby put every control bit back to its initial value
  assign regs_to_initial = !reset_pin_ok || (state_reg == ST_HW_STANDBY);

  always_ff @(posedge clk_sys) begin
    if (reset || regs_to_initial) begin
      system_control_reg <= SYS_CTRL_RESET;
    end else if (reg_write && reg_addr == SYS_CTRL_OFFSET) begin
      // Select bit is changed by a write and cleared by reset pin or hardware standby, never by an interrupt exit
      system_control_reg <= reg_wdata;                                    // [RULE11]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset || regs_to_initial) begin
      module_halt_ctrl_high <= HALT_HIGH_RESET;                           // [RULE8]
    end else if (reg_write && reg_addr == HALT_HIGH_OFFSET) begin
      module_halt_ctrl_high <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset || regs_to_initial) begin
      module_halt_ctrl_low <= HALT_LOW_RESET;                             // [RULE8]
    end else if (reg_write && reg_addr == HALT_LOW_OFFSET) begin
      module_halt_ctrl_low <= reg_wdata;
    end
  end

  assign onchip_ram_enable = system_control_reg[RAM_ENABLE_BIT];

  // ==========================================================================
  // Register read, data one cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        SYS_CTRL_OFFSET:  reg_rdata <= system_control_reg;
        HALT_HIGH_OFFSET: reg_rdata <= module_halt_ctrl_high;
        HALT_LOW_OFFSET:  reg_rdata <= module_halt_ctrl_low;
        STATUS_OFFSET:    reg_rdata <= {6'h00, state_reg};
        default:          reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ==========================================================================
  // Per-module halt and reset
  for (genvar i = 0; i < MOD_COUNT; i++) begin : g_module
    module_standby_gate #(
      .HOLD_IN_SOFT (i == DRAM_MODULE_BIT)                                // [RULE3] [RULE10]
    ) u_gate (
      .clk_sys         (clk_sys),
      .reset           (reset),
      .halt_bit        (module_halt_ctrl[i]),                             // [RULE6] [RULE7]
      .sw_standby_next (sw_next),                                         // [RULE10]
      .hw_standby_next (hw_next),                                         // [RULE4]
      .module_halt     (periph_halt[i]),
      .module_reset    (periph_reset[i])
    );
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk_sys);
  endclocking

  default disable iff (reset);

  sequence s_enter_sw;
    (state_reg == ST_RUN) && sleep_exec && sleep_target_select
      && standby_ok && reset_pin_ok;
  endsequence

  sequence s_irq_exit;
    (state_reg == ST_SW_STANDBY) && standby_ok && reset_pin_ok && irq_seen && !nmi_seen;
  endsequence

  a_sw_entry_halts: assert property (s_enter_sw |=> core_halt && clock_stop && !io_hiz
                                     && clock_out_high) // [RULE1]
    else $error("software standby entry did not halt core and clock");

  a_sw_exit_wake: assert property (((state_reg == ST_SW_STANDBY) && standby_ok
                                    && (nmi_seen || irq_seen || !reset_pin_ok))
                                   |=> !core_halt && !clock_stop) // [RULE2]
    else $error("software standby did not end on a wake event");

  a_refresh_init: assert property ((state_next != ST_RUN)
                                   |=> refresh_init && periph_halt[DRAM_MODULE_BIT]) // [RULE3]
    else $error("refresh logic not initialised in standby");

  a_hw_entry_all: assert property (!standby_ok |=> io_hiz && core_regs_undefined
                                   && core_halt && (periph_reset == '1)) // [RULE4]
    else $error("hardware standby did not reset modules and float ports");

  a_module_halt: assert property ((state_next == ST_RUN)
                                  |=> ((($past(module_halt_ctrl) & ~periph_halt) == '0)
                                  && !clock_stop && !core_halt)) // [RULE6]
    else $error("module halt bit did not halt its module");

  a_module_reset: assert property (1'b1 |=> ((($past(module_halt_ctrl) & ~DRAM_MASK
                                   & ~periph_reset) == '0))) // [RULE7]
    else $error("module halt bit did not reset its module");

  a_halt_restore: assert property (regs_to_initial |=>
                                   module_halt_ctrl == {HALT_HIGH_RESET, HALT_LOW_RESET}) // [RULE8]
    else $error("halt registers not restored by reset or standby pin");

  a_sw_others_reset: assert property ((clock_out_high && !io_hiz)
                                      |-> ((periph_reset | DRAM_MASK) == '1)
                                      && !periph_reset[DRAM_MODULE_BIT]) // [RULE10]
    else $error("software standby module reset pattern wrong");

  a_select_kept: assert property (s_irq_exit |=> sleep_target_select && !core_halt) // [RULE11]
    else $error("select bit lost on interrupt exit");

  a_sleep_select: assert property (((state_reg == ST_RUN) && sleep_exec && !sleep_target_select
                                    && standby_ok && reset_pin_ok)
                                   |=> sleep_mode_req && !clock_stop) // [RULE11]
    else $error("sleep instruction with select bit 0 did not request sleep");

endmodule // power_down_ctrl

//--- sim/periph_model.sv
// Purpose: Peripheral-side model: sixteen modules with one program register each
// Assumes: Halt and reset levels come straight from the controller on the same clock
// Notes:   Writes to a halted module are lost, as on a peripheral whose clock is gated

`timescale 1ns/100ps

module periph_model (
  // Clock
  input  wire logic         clk_sys,
  // Controller side
  input  wire logic [15:0]  periph_halt,
  input  wire logic [15:0]  periph_reset,
  // Bench side
  input  wire logic         prog_write,
  input  wire logic [3:0]   prog_idx,
  input  wire logic [7:0]   prog_data,
  output logic      [127:0] mod_regs
);

  // ==========================================================================
  // Module registers
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < 16; i++) begin
      if (periph_reset[i]) begin
        mod_regs[i*8 +: 8] <= 8'h00;
      end else if (prog_write && prog_idx == 4'(i) && !periph_halt[i]) begin
        mod_regs[i*8 +: 8] <= prog_data;
      end
    end
  end

endmodule // periph_model

//--- sim/power_down_ctrl_tb.sv
// Purpose: Self-checking bench for the power-down mode controller
// Assumes: Pins are driven on the system clock; synchronisers add two edges
// Notes:   Random halt patterns come from a fixed-seed xorshift

`timescale 1ns/100ps

module power_down_ctrl_tb;
  import power_down_pkg::*;

  logic         clk_sys, reset, reg_write, reg_read, sleep_exec;
  logic [7:0]   reg_addr, reg_wdata, reg_rdata, prog_data, hv, lv;
  logic         core_halt, clock_stop, core_regs_undefined, sleep_mode_req;
  logic         standby_pin_n, reset_pin_n, nmi_pin, clock_out_high, io_hiz;
  logic [2:0]   irq_pin;
  logic [15:0]  periph_halt, periph_reset;
  logic         refresh_init, onchip_ram_enable, prog_write;
  logic [3:0]   prog_idx;
  logic [127:0] mod_regs;
  logic [31:0]  seed;
  int           error_cnt, samples_checked;

  power_down_ctrl i_power_down_ctrl (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .sleep_exec(sleep_exec), .core_halt(core_halt), .clock_stop(clock_stop),
    .core_regs_undefined(core_regs_undefined), .sleep_mode_req(sleep_mode_req),
    .standby_pin_n(standby_pin_n), .reset_pin_n(reset_pin_n), .nmi_pin(nmi_pin),
    .irq_pin(irq_pin), .clock_out_high(clock_out_high), .io_hiz(io_hiz),
    .periph_halt(periph_halt), .periph_reset(periph_reset), .refresh_init(refresh_init),
    .onchip_ram_enable(onchip_ram_enable));

  periph_model i_periph_model (.clk_sys(clk_sys), .periph_halt(periph_halt),
    .periph_reset(periph_reset), .prog_write(prog_write), .prog_idx(prog_idx),
    .prog_data(prog_data), .mod_regs(mod_regs));

  // ==========================================================================
  // Helpers
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic wrap_up;
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1 chk({8'h00, reg_rdata}, {8'h00, exp});
  endtask

  task automatic prog(input logic [3:0] idx, input logic [7:0] v);
    @(posedge clk_sys);
    prog_idx <= idx;
    prog_data <= v;
    prog_write <= 1'b1;
    @(posedge clk_sys);
    prog_write <= 1'b0;
    #1;
  endtask

  // Bounded wait on core_halt (sel 0) or io_hiz (sel 1)
  task automatic wait_for(input int sel, input logic lvl);
    int n;
    n = 0;
    while (((sel == 0) ? core_halt : io_hiz) !== lvl) begin
      @(posedge clk_sys);
      #1 n++;
      if (n > 20) begin
        error_cnt++;
        $display("[ERR] %0t wait timed out", $time);
        wrap_up();
      end
    end
  endtask

  task automatic enter_sw(input logic [7:0] sys);
    wr(SYS_CTRL_OFFSET, sys);
    @(posedge clk_sys);
    sleep_exec <= 1'b1;
    @(posedge clk_sys);
    sleep_exec <= 1'b0;
    #1 chk({13'h0, core_halt, clock_stop, clock_out_high}, 16'h0007);
    chk({14'h0, refresh_init, io_hiz}, 16'h0002);
    chk(periph_halt, 16'hffff);
    chk(periph_reset, ~DRAM_MASK);
    rdchk(STATUS_OFFSET, 8'h01);
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    {reg_write, reg_read, sleep_exec, nmi_pin, irq_pin, prog_write} = '0;
    {reg_addr, reg_wdata, prog_data, prog_idx} = '0;
    {standby_pin_n, reset_pin_n} = 2'b11;
    error_cnt = 0;
    samples_checked = 0;
    seed = 32'hbe72;
    reset = 1'b1;
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1 chk(periph_halt, 16'h7800);
    chk({15'h0, onchip_ram_enable}, 16'h0001);
    rdchk(SYS_CTRL_OFFSET, SYS_CTRL_RESET);
    rdchk(HALT_HIGH_OFFSET, HALT_HIGH_RESET);
    rdchk(HALT_LOW_OFFSET, HALT_LOW_RESET);
    rdchk(8'h40, 8'h00);
    wr(STATUS_OFFSET, 8'hff);
    rdchk(STATUS_OFFSET, 8'h00);
    // Module standby resets a module, blocks it, and a clear lets it be reprogrammed
    prog(4'h3, 8'h5a);
    prog(4'ha, 8'ha3);
    chk({8'h00, mod_regs[31:24]}, 16'h005a);
    wr(HALT_LOW_OFFSET, 8'h08);
    repeat (3) @(posedge clk_sys);
    #1 chk({8'h00, mod_regs[31:24]}, 16'h0000);
    chk({15'h0, core_halt | clock_stop}, 16'h0000);
    prog(4'h3, 8'h11);
    chk({8'h00, mod_regs[31:24]}, 16'h0000);
    wr(HALT_LOW_OFFSET, 8'h00);
    repeat (3) @(posedge clk_sys);
    prog(4'h3, 8'ha5);
    chk({8'h00, mod_regs[31:24]}, 16'h00a5);
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      hv = seed[15:8];
      lv = seed[7:0];
      wr(HALT_HIGH_OFFSET, hv);
      wr(HALT_LOW_OFFSET, lv);
      repeat (3) @(posedge clk_sys);
      #1 chk(periph_halt, {hv, lv});
      chk(periph_reset, {hv, lv} & ~DRAM_MASK);
      rdchk(HALT_HIGH_OFFSET, hv);
      rdchk(HALT_LOW_OFFSET, lv);
    end
    // Software standby left by NMI, each IRQ line and the reset pin
    wr(HALT_HIGH_OFFSET, 8'h00);
    wr(HALT_LOW_OFFSET, 8'h00);
    for (int s = 0; s < 5; s++) begin
      enter_sw(8'h89);
      @(posedge clk_sys);
      sleep_exec <= 1'b1;
      @(posedge clk_sys);
      sleep_exec <= 1'b0;
      if (s == 0) nmi_pin <= 1'b1;
      else if (s == 4) reset_pin_n <= 1'b0;
      else irq_pin[s-1] <= 1'b1;
      wait_for(0, 1'b0);
      repeat (3) @(posedge clk_sys);
      #1 chk(periph_halt, (s == 4) ? 16'h7800 : 16'h0000);
      chk({15'h0, clock_out_high}, 16'h0000);
      @(posedge clk_sys);
      {nmi_pin, irq_pin} <= '0;
      reset_pin_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      rdchk(SYS_CTRL_OFFSET, (s == 4) ? 8'h09 : 8'h89);
      wr(HALT_HIGH_OFFSET, 8'h00);
    end
    #1 chk({8'h00, mod_regs[87:80]}, 16'h00a3);
    chk({8'h00, mod_regs[31:24]}, 16'h0000);
    // Select bit clear gives sleep mode, not standby
    wr(SYS_CTRL_OFFSET, 8'h09);
    @(posedge clk_sys);
    sleep_exec <= 1'b1;
    @(posedge clk_sys);
    sleep_exec <= 1'b0;
    #1 chk({14'h0, core_halt, sleep_mode_req}, 16'h0001);
    @(posedge clk_sys);
    #1 chk({15'h0, sleep_mode_req}, 16'h0000);
    // Hardware standby from software standby, with RAM enable cleared first
    enter_sw(8'h88);
    chk({15'h0, onchip_ram_enable}, 16'h0000);
    @(posedge clk_sys);
    standby_pin_n <= 1'b0;
    wait_for(1, 1'b1);
    chk({14'h0, core_regs_undefined, core_halt}, 16'h0003);
    chk({14'h0, clock_stop, refresh_init}, 16'h0003);
    chk(periph_reset & periph_halt, 16'hffff);
    wr(HALT_LOW_OFFSET, 8'hff);
    rdchk(HALT_LOW_OFFSET, 8'h00);
    rdchk(SYS_CTRL_OFFSET, 8'h09);
    rdchk(STATUS_OFFSET, 8'h02);
    @(posedge clk_sys);
    standby_pin_n <= 1'b1;
    wait_for(1, 1'b0);
    repeat (2) @(posedge clk_sys);
    #1 chk({14'h0, core_halt, core_regs_undefined}, 16'h0000);
    chk(periph_halt, 16'h7800);
    wrap_up();
  end

endmodule // power_down_ctrl_tb
